//--- design/sfm_defines.svh
// Supply fault monitor: command codes, field positions and constants.
// Assumes inclusion by bare name from the design files.
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

// ==========================================================================
// Command codes of the register port
`define SFM_CMD_FAULT     8'h00
`define SFM_CMD_LATCH_EN  8'h01
`define SFM_CMD_LATCHED   8'h02
`define SFM_CMD_FAULT_SUM 8'h03
`define SFM_CMD_IO        8'h04
`define SFM_CMD_MON       8'h05
`define SFM_CMD_OV_BASE   8'h10
`define SFM_CMD_UV_BASE   8'h18
`define SFM_CMD_RES_BASE  8'h20

// ==========================================================================
// Channel count and fault vector layout
`define SFM_NUM_CH     3'd6
`define SFM_NUM_FLT    14
`define SFM_FLT_TRIM1  12
`define SFM_FLT_TRIM0  13
`define SFM_CH1A       3
`define SFM_CH0A       5

// ==========================================================================
// I/O control word fields
`define SFM_IO_FN0_LSB  0
`define SFM_IO_FN1_LSB  2
`define SFM_IO_VAL0     4
`define SFM_IO_VAL1     5
`define SFM_IO_ALERT    6
`define SFM_IO_OVR      7
`define SFM_IO_ALARM_RB 8

// ==========================================================================
// Limit values that can never trip, reset values, strap settle time
`define SFM_OV_OFF     15'h3fff
`define SFM_UV_OFF     15'h4000
`define SFM_STRAP_WAIT 2'h3
`define SFM_MON_RST    6'h00

`endif

//--- design/sfm_pkg.sv
// Supply fault monitor: shared types.
// Assumes nothing beyond a SystemVerilog compiler.
package sfm_pkg;

	// ======================================================================
	// Scalar types
	typedef logic [2:0]  sfm_chan_t;
	typedef logic [7:0]  sfm_cmd_t;
	typedef logic [15:0] sfm_word_t;

	// ======================================================================
	// General-purpose pin functions
	typedef enum logic [1:0] {
		SFM_FN_OFF  = 2'b00,
		SFM_FN_FLAG = 2'b01,
		SFM_FN_OUT  = 2'b10,
		SFM_FN_IN   = 2'b11
	} sfm_pin_fn_e;

endpackage

//--- design/sfm_sync.sv
// Two-stage synchroniser for pin levels.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module sfm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;

	// ======================================================================
	// First stage is read only by the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule
`default_nettype wire

//--- design/sfm_limit_mem.sv
// Small limit store with one write port and a registered read port.
// Assumes the host programs every word before the contents are used.
`timescale 1ns/10ps
`default_nettype none

module sfm_limit_mem #(
	parameter int W  = 15,
	parameter int AW = 3
) (
	// Clock
	input  wire logic          clk_i,
	// Write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [W-1:0]  wr_data_i,
	// Read port, data one cycle after the address
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [W-1:0]  rd_data_o
);

	logic [W-1:0] mem_q [2**AW];

	// ======================================================================
	// No reset: limits have no defined value until written
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem_q[rd_addr_i];
	end

endmodule
`default_nettype wire

//--- design/sfm_supply_fault_monitor.sv
// Supply fault monitor: limit checks, fault latching, alarm and GP pins.
// Assumes a decoded command port from the serial interface, results from
// the conversion sequencer, and open-drain pads resolved outside.
`timescale 1ns/10ps
`default_nettype none
`include "sfm_defines.svh"

// Summary of operation
// - Fourteen faults: six UV, six OV, two trim
// - OV flag set above limit, else cleared
// - OV limit 3fff never trips
// - UV flag set below limit, else cleared
// - UV limit 4000 never trips
// - Fifteen-bit signed values, signed compares
// - Flags update only for selected channels
// - Trim code at end stop sets fault
// - Fault status read has no side effects
// - Window flag when no voltage fault
// - Trim flag when either trim fault
// - Enabled fault sets latch same cycle
// - Clearing enable clears latch at once
// - Latched status read clears all latches
// - Summary read reports any latch, no clear
// - Enabled alarm pulls low on any latch
// - Function 10: open-drain output of value
// - Function 11: input, level read back
// - Reset: outputs at inverse of strap
// - Pin levels readable whatever the function
// - Servo channel faults offered as triggers
// - Override blocks conversions, host writes results
module sfm_supply_fault_monitor
	import sfm_pkg::*;
#(
	parameter int RES_W  = 15,
	parameter int TRIM_W = 8
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	// Conversion results from the sequencer
	input  wire logic                conv_valid_i,
	input  wire sfm_pkg::sfm_chan_t  conv_chan_i,
	input  wire logic [RES_W-1:0]    conv_result_i,
	input  wire logic                pass_done_i,
	// Trim current codes
	input  wire logic [TRIM_W-1:0]   trim0_code_i,
	input  wire logic [TRIM_W-1:0]   trim1_code_i,
	// Decoded command port
	input  wire sfm_pkg::sfm_cmd_t   reg_addr_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	input  wire sfm_pkg::sfm_word_t  reg_wdata_i,
	output sfm_pkg::sfm_word_t       reg_rdata_o,
	// Sequencer controls
	output logic [5:0]               conv_select_o,
	output logic                     result_write_override_o,
	// Servo restart triggers
	output logic                     servo_fault_ch0_o,
	output logic                     servo_fault_ch1_o,
	// Strap and open-drain pins
	input  wire logic                port_default_strap_i,
	input  wire logic                gp0_i,
	output logic                     gp0_o,
	output logic                     gp0_oe_o,
	input  wire logic                gp1_i,
	output logic                     gp1_o,
	output logic                     gp1_oe_o,
	input  wire logic                alarm_i,
	output logic                     alarm_out_n_o,
	output logic                     alarm_oe_o
);

	localparam int NF = `SFM_NUM_FLT;

	// ======================================================================
	// Elaboration checks
	if (RES_W < 2 || RES_W > 16) begin : g_bad_res
		$error("RES_W must lie in 2..16");
	end
	if (TRIM_W < 1 || TRIM_W > 16) begin : g_bad_trim
		$error("TRIM_W must lie in 1..16");
	end

	// ======================================================================
	// Helper functions
	function automatic logic in_win(input sfm_cmd_t a, input sfm_cmd_t b);
		return (a[7:3] == b[7:3]) && (a[2:0] < `SFM_NUM_CH);
	endfunction

	function automatic logic at_stop(input logic [TRIM_W-1:0] t);
		return (t == '0) || (t == '1);
	endfunction

	// Open-drain pull request for one pin
	function automatic logic pin_pull(input sfm_pin_fn_e fn,
		input logic flag, input logic val);
		return ((fn == SFM_FN_FLAG) && !flag) ||
			((fn == SFM_FN_OUT) && !val);
	endfunction

	// ======================================================================
	// State
	logic [NF-1:0]     inst_q;
	logic [NF-1:0]     en_q;
	logic [NF-1:0]     la_q;
	logic [5:0]        sel_q;
	sfm_pin_fn_e       fn0_q;
	sfm_pin_fn_e       fn1_q;
	logic              val0_q;
	logic              val1_q;
	logic              alarm_en_n_q;
	logic              ovr_q;
	logic [1:0]        strap_cnt_q;
	logic              upd_v_q;
	sfm_chan_t         upd_ch_q;
	logic [RES_W-1:0]  upd_res_q;
	logic [3:0]        pin_s;
	logic [RES_W-1:0]  ov_lim;
	logic [RES_W-1:0]  uv_lim;

	// ======================================================================
	// Pin synchronisers: strap, gp0, gp1, alarm
	sfm_sync #(
		.W (4)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({alarm_i, gp1_i, gp0_i, port_default_strap_i}),
		.q_o     (pin_s)
	);

	// ======================================================================
	// Command decode
	wire wr_en  = reg_wr_i && (reg_addr_i == `SFM_CMD_LATCH_EN);
	wire wr_io  = reg_wr_i && (reg_addr_i == `SFM_CMD_IO);
	wire wr_mon = reg_wr_i && (reg_addr_i == `SFM_CMD_MON);
	wire wr_ov  = reg_wr_i && in_win(reg_addr_i, `SFM_CMD_OV_BASE);
	wire wr_uv  = reg_wr_i && in_win(reg_addr_i, `SFM_CMD_UV_BASE);
	wire rd_la  = reg_rd_i && (reg_addr_i == `SFM_CMD_LATCHED);
	wire wr_res = reg_wr_i && ovr_q &&
		in_win(reg_addr_i, `SFM_CMD_RES_BASE);
	wire strap_busy = (strap_cnt_q != `SFM_STRAP_WAIT);

	// ======================================================================
	// Result acceptance
	// sequencer gated
	wire conv_hit = conv_valid_i && !ovr_q && (conv_chan_i < `SFM_NUM_CH)
		&& sel_q[conv_chan_i];
	wire host_hit = wr_res && sel_q[reg_addr_i[2:0]];
	wire acc      = conv_hit || host_hit;
	wire sfm_chan_t acc_ch = conv_hit ? conv_chan_i : reg_addr_i[2:0];
	wire [RES_W-1:0] acc_res = conv_hit ? conv_result_i :
		reg_wdata_i[RES_W-1:0];

	// Limit stores, read aligned with the staged result
	// limits unreset
	sfm_limit_mem #(
		.W  (RES_W),
		.AW (3)
	) u_ov_mem (
		.clk_i     (clk_i),
		.wr_en_i   (wr_ov),
		.wr_addr_i (reg_addr_i[2:0]),
		.wr_data_i (reg_wdata_i[RES_W-1:0]),
		.rd_addr_i (acc_ch),
		.rd_data_o (ov_lim)
	);

	sfm_limit_mem #(
		.W  (RES_W),
		.AW (3)
	) u_uv_mem (
		.clk_i     (clk_i),
		.wr_en_i   (wr_uv),
		.wr_addr_i (reg_addr_i[2:0]),
		.wr_data_i (reg_wdata_i[RES_W-1:0]),
		.rd_addr_i (acc_ch),
		.rd_data_o (uv_lim)
	);

	// Stage the result so it meets its limits a cycle later
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			upd_v_q   <= 1'b0;
			upd_ch_q  <= '0;
			upd_res_q <= '0;
		end else begin
			upd_v_q   <= acc;
			upd_ch_q  <= acc_ch;
			upd_res_q <= acc_res;
		end
	end

	// ======================================================================
	// Limit comparisons
	// signed compare
	wire ov_hit = $signed(upd_res_q) > $signed(ov_lim);
	wire uv_hit = $signed(upd_res_q) < $signed(uv_lim);

	// ======================================================================
	// Fault vector update masks and new values
	logic [NF-1:0] upd_mask;
	logic [NF-1:0] new_val;
	for (genvar c = 0; c < 6; c++) begin : g_ch
		wire hit = upd_v_q && (upd_ch_q == 3'(c));
		assign upd_mask[2*c]   = hit;
		assign new_val[2*c]    = uv_hit;
		assign upd_mask[2*c+1] = hit;
		assign new_val[2*c+1]  = ov_hit;
	end
	assign upd_mask[`SFM_FLT_TRIM1] = pass_done_i;
	assign new_val[`SFM_FLT_TRIM1]  = at_stop(trim1_code_i);
	assign upd_mask[`SFM_FLT_TRIM0] = pass_done_i;
	assign new_val[`SFM_FLT_TRIM0]  = at_stop(trim0_code_i);

	wire [NF-1:0] set_ev = upd_mask & new_val;
	wire [NF-1:0] inst_d = (inst_q & ~upd_mask) | set_ev;
	wire [NF-1:0] en_d   = wr_en ? reg_wdata_i[NF-1:0] : en_q;
	wire [NF-1:0] la_d   = en_d & ((la_q & ~{NF{rd_la}}) | set_ev);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			inst_q <= '0;
			en_q   <= '0;
			la_q   <= '0;
		end else begin
			inst_q <= inst_d;
			en_q   <= en_d;
			la_q   <= la_d;
		end
	end

	// ======================================================================
	// Control registers: monitor select and I/O control
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_q        <= `SFM_MON_RST;
			fn0_q        <= SFM_FN_OUT;
			fn1_q        <= SFM_FN_OUT;
			alarm_en_n_q <= 1'b1;
			ovr_q        <= 1'b0;
		end else begin
			if (wr_mon) begin
				sel_q <= reg_wdata_i[5:0];
			end
			if (wr_io) begin
				fn0_q <= sfm_pin_fn_e'(reg_wdata_i[`SFM_IO_FN0_LSB +: 2]);
				fn1_q <= sfm_pin_fn_e'(reg_wdata_i[`SFM_IO_FN1_LSB +: 2]);
				alarm_en_n_q <= reg_wdata_i[`SFM_IO_ALERT];
				ovr_q <= reg_wdata_i[`SFM_IO_OVR];
			end
		end
	end

	// Pin values: inverted strap copy after reset, host writes afterwards
	// inverse strap default
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_cnt_q <= '0;
			val0_q      <= 1'b1;
			val1_q      <= 1'b1;
		end else if (strap_busy) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			val0_q      <= !pin_s[0];
			val1_q      <= !pin_s[0];
		end else if (wr_io) begin
			val0_q <= reg_wdata_i[`SFM_IO_VAL0];
			val1_q <= reg_wdata_i[`SFM_IO_VAL1];
		end
	end

	// ======================================================================
	// Summary flags and pin drive
	// no voltage fault
	wire in_window = ~|inst_q[11:0];
	wire trim_flag = inst_q[`SFM_FLT_TRIM1] | inst_q[`SFM_FLT_TRIM0];
	wire any_la    = |la_q;

	// Pads only ever pull low; release lets the pull-up win
	// open-drain value
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gp0_oe_o   <= 1'b0;
			gp1_oe_o   <= 1'b0;
			alarm_oe_o <= 1'b0;
			servo_fault_ch0_o <= 1'b0;
			servo_fault_ch1_o <= 1'b0;
		end else begin
			gp0_oe_o   <= pin_pull(fn0_q, in_window, val0_q);
			gp1_oe_o   <= pin_pull(fn1_q, trim_flag, val1_q);
			alarm_oe_o <= !alarm_en_n_q && any_la;
			servo_fault_ch0_o <= |inst_q[2*`SFM_CH0A +: 2];
			servo_fault_ch1_o <= |inst_q[2*`SFM_CH1A +: 2];
		end
	end

	assign gp0_o                   = 1'b0;
	assign gp1_o                   = 1'b0;
	assign alarm_out_n_o           = 1'b0;
	assign conv_select_o           = sel_q;
	assign result_write_override_o = ovr_q;

	// ======================================================================
	// Read data
	// live pin levels
	wire sfm_word_t io_word = {7'h00, pin_s[3], ovr_q, alarm_en_n_q,
		pin_s[2], pin_s[1], fn1_q, fn0_q};
	wire sfm_word_t rd_sel =
		(reg_addr_i == `SFM_CMD_FAULT)     ? {2'h0, inst_q} :
		(reg_addr_i == `SFM_CMD_LATCH_EN)  ? {2'h0, en_q} :
		(reg_addr_i == `SFM_CMD_LATCHED)   ? {2'h0, la_q} :
		(reg_addr_i == `SFM_CMD_FAULT_SUM) ? {15'h0000, any_la} :
		(reg_addr_i == `SFM_CMD_IO)        ? io_word :
		(reg_addr_i == `SFM_CMD_MON)       ? {10'h000, sel_q} :
		16'h0000;

	// Read word holds until the next read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_sel;
		end
	end

	// ======================================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_set_en;
		upd_v_q && ov_hit && en_q[2*upd_ch_q+1] && !wr_en;
	endsequence

	ov_flag_a: assert property (
		upd_v_q |=> inst_q[2*$past(upd_ch_q)+1] == $past(ov_hit))
		else $error("over-voltage flag does not follow compare");

	uv_flag_a: assert property (
		upd_v_q |=> inst_q[2*$past(upd_ch_q)] == $past(uv_hit))
		else $error("under-voltage flag does not follow compare");

	ov_inhibit_a: assert property (
		(upd_v_q && ov_lim == `SFM_OV_OFF) |-> !ov_hit)
		else $error("top over-voltage limit tripped");

	uv_inhibit_a: assert property (
		(upd_v_q && uv_lim == `SFM_UV_OFF) |-> !uv_hit)
		else $error("bottom under-voltage limit tripped");

	unsel_hold_a: assert property (
		(conv_valid_i && !sel_q[conv_chan_i] && !reg_wr_i)
		|=> !upd_v_q ##1 inst_q[11:0] == $past(inst_q[11:0]))
		else $error("unselected channel changed a flag");

	trim_stop_a: assert property (
		(pass_done_i && at_stop(trim0_code_i)) |=> inst_q[`SFM_FLT_TRIM0])
		else $error("trim end stop not flagged");

	latch_set_a: assert property (
		s_set_en |=> la_q[2*$past(upd_ch_q)+1] && inst_q[2*$past(upd_ch_q)+1])
		else $error("enabled fault not latched with its flag");

	en_clear_a: assert property (
		(la_q & ~en_q) == '0)
		else $error("latched bit set while its enable is low");

	la_read_a: assert property (
		(rd_la && set_ev == '0) |=> la_q == '0)
		else $error("latched status read did not clear latches");

	sum_keep_a: assert property (
		(reg_rd_i && reg_addr_i == `SFM_CMD_FAULT_SUM && !wr_en &&
		set_ev == '0) |=> la_q == $past(la_q) && reg_rdata_o[0] == |la_q)
		else $error("summary read disturbed the latches");

	alarm_drive_a: assert property (
		(!alarm_en_n_q && any_la) |=> alarm_oe_o)
		else $error("alarm not pulled low on a latched fault");

	gp_out_a: assert property (
		(fn0_q == SFM_FN_OUT) |=> gp0_oe_o == !$past(val0_q))
		else $error("pin 0 output does not follow its value");

	override_a: assert property (
		(ovr_q && !reg_wr_i) |=> !upd_v_q)
		else $error("conversion accepted during override");

endmodule
`default_nettype wire

//--- tb/sfm_pad_model.sv
// Pad model: pull-ups on the open-drain pins, external pull-down on pin 1.
// Assumes the device only ever pulls its pads low through the enables.
`timescale 1ns/10ps
`default_nettype none

module sfm_pad_model (
	// Device pad enables
	input  wire logic gp0_oe_i,
	input  wire logic gp1_oe_i,
	input  wire logic alarm_oe_i,
	// Board driver that can hold pin 1 low
	input  wire logic ext_low1_i,
	// Resolved wire levels
	output logic      gp0_lvl_o,
	output logic      gp1_lvl_o,
	output logic      alarm_lvl_o
);
	// ======================================================================
	// Wired-AND levels, pull-ups win when nobody pulls down
	// open drain wires
	assign gp0_lvl_o   = ~gp0_oe_i;
	assign gp1_lvl_o   = ~(gp1_oe_i | ext_low1_i);
	assign alarm_lvl_o = ~alarm_oe_i;
endmodule
`default_nettype wire

//--- tb/sfm_supply_fault_monitor_bench.sv
// Bench for the supply fault monitor: command port tasks and checks.
// Assumes the pad model resolves the open-drain pins.
`timescale 1ns/10ps
`default_nettype none

module sfm_supply_fault_monitor_bench;
	import sfm_pkg::*;
	// ======================================================================
	// Signals
	logic        clk, rst_n, cv, pd, rd, wr, strap, ext1;
	sfm_chan_t   ch;
	logic [14:0] res;
	logic [7:0]  t0, t1;
	sfm_cmd_t    addr;
	sfm_word_t   wd, rdv;
	logic [5:0]  sel;
	logic        ovr, s0, s1, g0, g1, g0e, g1e, al, ale;
	int          err_total, total_checks;

	sfm_supply_fault_monitor u_dut (
		.clk_i(clk), .rst_n_i(rst_n),
		.conv_valid_i(cv), .conv_chan_i(ch), .conv_result_i(res),
		.pass_done_i(pd), .trim0_code_i(t0), .trim1_code_i(t1),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wd), .reg_rdata_o(rdv),
		.conv_select_o(sel), .result_write_override_o(ovr),
		.servo_fault_ch0_o(s0), .servo_fault_ch1_o(s1),
		.port_default_strap_i(strap),
		.gp0_i(g0), .gp0_o(), .gp0_oe_o(g0e),
		.gp1_i(g1), .gp1_o(), .gp1_oe_o(g1e),
		.alarm_i(al), .alarm_out_n_o(), .alarm_oe_o(ale)
	);

	sfm_pad_model u_pad (
		.gp0_oe_i(g0e), .gp1_oe_i(g1e), .alarm_oe_i(ale),
		.ext_low1_i(ext1),
		.gp0_lvl_o(g0), .gp1_lvl_o(g1), .alarm_lvl_o(al)
	);

	// ======================================================================
	// Clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ======================================================================
	// Tasks
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Lands just after an edge so settled outputs are sampled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wreg(input sfm_cmd_t a, input sfm_word_t d);
		@(posedge clk);
		addr <= a;
		wd   <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read answer is registered, so wait one edge past the taking edge
	task automatic rchk(input string what, input sfm_cmd_t a,
		input sfm_word_t m, input sfm_word_t e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		tick(1);
		chk(what, rdv & m, e);
	endtask

	task automatic conv(input int c, input logic [14:0] v);
		@(posedge clk);
		ch  <= c[2:0];
		res <= v;
		cv  <= 1'b1;
		@(posedge clk);
		cv <= 1'b0;
		tick(3);
	endtask

	task automatic poll(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk);
		t0 <= a;
		t1 <= b;
		pd <= 1'b1;
		@(posedge clk);
		pd <= 1'b0;
		tick(3);
	endtask

	function automatic sfm_word_t iow(input logic [1:0] f0, f1,
		input logic v0, v1, aen_n, ov);
		return {8'h00, ov, aen_n, v1, v0, f1, f0};
	endfunction

	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ======================================================================
	// Watchdog, ample margin over the roughly 450-cycle sequence
	initial begin
		repeat (8000) @(posedge clk);
		err_total++;
		print_verdict();
	end

	// ======================================================================
	// Main sequence
	initial begin
		rst_n = 1'b0; cv = 1'b0; pd = 1'b0; rd = 1'b0; wr = 1'b0;
		strap = 1'b1; ext1 = 1'b0; ch = '0; res = '0;
		t0 = 8'h40; t1 = 8'h40; addr = '0; wd = '0;
		err_total = 0; total_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		tick(6);
		rchk("fault", 8'h00, 16'h3fff, 16'h0000);
		rchk("latch enable", 8'h01, 16'h3fff, 16'h0000);
		rchk("latched", 8'h02, 16'h3fff, 16'h0000);
		chk("alarm oe", 16'(ale), 16'h0000);
		chk("gp0 oe", 16'(g0e), 16'h0001);
		chk("gp1 oe", 16'(g1e), 16'h0001);
		rchk("io levels", 8'h04, 16'h01f0, 16'h0140);
		rchk("unmapped", 8'h7f, 16'hffff, 16'h0000);
		for (int c = 0; c < 6; c++) begin
			wreg(8'h10 + 8'(c), 16'h0100);
			wreg(8'h18 + 8'(c), 16'h7f00);
		end
		wreg(8'h05, 16'h003f);
		wreg(8'h04, iow(2'b01, 2'b01, 1'b0, 1'b0, 1'b1, 1'b0));
		tick(2);
		chk("select", {10'h000, sel}, 16'h003f);
		for (int c = 0; c < 6; c++) begin
			conv(c, 15'h0101);
			rchk("ov set", 8'h00, 16'h0fff, 16'h1 << (2*c+1));
			chk("window low", 16'(g0e), 16'h0001);
			conv(c, 15'h0100);
			rchk("ov equal", 8'h00, 16'h0fff, 16'h0000);
			conv(c, 15'h7eff);
			rchk("uv set", 8'h00, 16'h0fff, 16'h1 << (2*c));
			conv(c, 15'h7f00);
			rchk("uv equal", 8'h00, 16'h0fff, 16'h0000);
		end
		chk("window high", 16'(g0e), 16'h0000);
		conv(1, 15'h7fff);
		rchk("signed", 8'h00, 16'h0fff, 16'h0000);
		wreg(8'h12, 16'h3fff);
		wreg(8'h1a, 16'h4000);
		conv(2, 15'h3fff);
		rchk("ov off", 8'h00, 16'h0fff, 16'h0000);
		conv(2, 15'h4000);
		rchk("uv off", 8'h00, 16'h0fff, 16'h0000);
		conv(0, 15'h0101);
		wreg(8'h05, 16'h003e);
		conv(0, 15'h0000);
		rchk("hold", 8'h00, 16'h0fff, 16'h0002);
		wreg(8'h05, 16'h003f);
		conv(0, 15'h0000);
		poll(8'h00, 8'h80);
		rchk("trim0", 8'h00, 16'h3000, 16'h2000);
		chk("trim pin", 16'(g1e), 16'h0000);
		poll(8'h7f, 8'hff);
		rchk("trim1", 8'h00, 16'h3000, 16'h1000);
		poll(8'h01, 8'hfe);
		rchk("trim none", 8'h00, 16'h3fff, 16'h0000);
		chk("trim pin off", 16'(g1e), 16'h0001);
		wreg(8'h01, 16'h3fff);
		wreg(8'h04, iow(2'b01, 2'b01, 1'b0, 1'b0, 1'b0, 1'b0));
		conv(3, 15'h0101);
		chk("servo ch1", {14'h0, s1, s0}, 16'h0002);
		chk("alarm low", 16'(ale), 16'h0001);
		rchk("alarm pin", 8'h04, 16'h0100, 16'h0000);
		rchk("summary", 8'h03, 16'h0001, 16'h0001);
		rchk("latched", 8'h02, 16'h3fff, 16'h0080);
		rchk("latch read", 8'h02, 16'h3fff, 16'h0000);
		rchk("summary clr", 8'h03, 16'h0001, 16'h0000);
		rchk("fault kept", 8'h00, 16'h3fff, 16'h0080);
		chk("alarm off", 16'(ale), 16'h0000);
		conv(3, 15'h0101);
		conv(3, 15'h0100);
		rchk("sticky", 8'h03, 16'h0001, 16'h0001);
		wreg(8'h01, 16'h0000);
		rchk("enable clr", 8'h03, 16'h0001, 16'h0000);
		conv(5, 15'h7eff);
		chk("servo ch0", {14'h0, s1, s0}, 16'h0001);
		conv(5, 15'h7f00);
		wreg(8'h04, iow(2'b10, 2'b11, 1'b0, 1'b0, 1'b1, 1'b0));
		tick(2);
		chk("od low", 16'(g0e), 16'h0001);
		wreg(8'h04, iow(2'b10, 2'b11, 1'b1, 1'b0, 1'b1, 1'b0));
		tick(2);
		chk("od high", 16'(g0e), 16'h0000);
		chk("input", 16'(g1e), 16'h0000);
		@(posedge clk);
		ext1 <= 1'b1;
		tick(4);
		rchk("in low", 8'h04, 16'h0030, 16'h0010);
		@(posedge clk);
		ext1 <= 1'b0;
		tick(4);
		rchk("in high", 8'h04, 16'h0030, 16'h0030);
		wreg(8'h04, iow(2'b10, 2'b11, 1'b1, 1'b0, 1'b1, 1'b1));
		tick(1);
		chk("override", 16'(ovr), 16'h0001);
		conv(4, 15'h0101);
		rchk("blocked", 8'h00, 16'h0fff, 16'h0000);
		wreg(8'h24, 16'h0101);
		tick(3);
		rchk("host result", 8'h00, 16'h0fff, 16'h0200);
		wreg(8'h00, 16'hffff);
		rchk("read only", 8'h00, 16'h3fff, 16'h0200);
		// second reset, strap low this time
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		tick(6);
		chk("gp0 oe strap low", 16'(g0e), 16'h0000);
		chk("gp1 oe strap low", 16'(g1e), 16'h0000);
		rchk("io after reset", 8'h04, 16'h00ff, 16'h007a);
		rchk("fault after reset", 8'h00, 16'h3fff, 16'h0000);
		// released function never pulls, even at value 0
		wreg(8'h04, iow(2'b00, 2'b00, 1'b0, 1'b0, 1'b1, 1'b0));
		tick(2);
		chk("released pins", 16'({g1e, g0e}), 16'h0000);
		print_verdict();
	end
endmodule
`default_nettype wire
